// ===== tb.sv
// Self-checking bench for utc_top with the host line model.
// Assumes a 200 MHz core_clk as the only clock.
`timescale 1ns/1ps
module tb;
	import utc_pkg::*;
	logic       core_clk = 0, rst = 1, sfr_wr = 0, sfr_rd = 0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, pipe_proto_addr, rv;
	logic       sfr_hit, plus_pin_in, minus_pin_in, diff_rx_pin_in, vbus_pin_in;
	logic       plus_pin_out, plus_pin_oe_n, minus_pin_out, minus_pin_oe_n;
	logic       pullup_plus_on, pullup_minus_on, xcvr_suspend, full_speed;
	logic       eng_tx_en = 0, eng_tx_plus = 0, eng_tx_minus = 0;
	logic       eng_rx_plus, eng_rx_minus, eng_rx_diff, pipe_valid;
	logic [3:0] tok_endpoint = 4'h0;
	logic [2:0] pipe_index;
	logic       tok_is_in = 0, host_drive = 0, host_plus = 0, host_minus = 0, vbus_on = 0;
	int         fails = 0, checks_done = 0;
	// Row: wdata, vbus, status, expected {pullups, suspend, speed, outs, oe_n}, mask
	logic [27:0] rows [7] = '{28'hE7E93F3, 28'h87863F3, 28'hA0033F3, 28'hC8E48FF,
		28'h50104FF, 28'hF8890FF, 28'h18023F3};
	utc_top i_utc_top (.*);
	utc_host_model i_utc_host_model (.*);
	initial forever #2.5 core_clk = ~core_clk;
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge core_clk);
		sfr_wr <= 1'b0;
		repeat (3) @(posedge core_clk);
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge core_clk);
		sfr_rd <= 1'b0;
		#1 rv = sfr_rdata;
	endtask : rd
	task automatic report_and_stop;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (5000) @(posedge core_clk);
		fails++;
		report_and_stop();
	end
	initial begin
		logic [27:0] r;
		logic [2:0]  ix;
		int          ep;
		// Clock runs from time zero, so it is active before any enable
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		rd(UTC_XCVR_CTRL_ADDR);
		chk(rv, UTC_XCVR_CTRL_RESET);
		foreach (rows[i]) begin
			r = rows[i];
			vbus_on <= r[19];
			wr(UTC_XCVR_CTRL_ADDR, r[27:20]);
			chk({pullup_plus_on, pullup_minus_on, xcvr_suspend, full_speed, plus_pin_out,
				minus_pin_out, plus_pin_oe_n, minus_pin_oe_n} & r[7:0], r[15:8] & r[7:0]);
			rd(UTC_XCVR_CTRL_ADDR);
			chk(rv & (r[13] ? 8'hF8 : 8'hFF), {r[27:23], r[13] ? 3'h0 : r[18:16]});
		end
		// Unmapped write is dropped, unmapped read gives zero
		wr(8'hD6, 8'hFF);
		rd(8'hD6);
		chk(rv, 8'h00);
		rd(UTC_XCVR_CTRL_ADDR);
		chk(rv & 8'hF8, 8'h18);
		wr(UTC_XCVR_CTRL_ADDR, 8'h40);
		eng_tx_en <= 1'b1;
		eng_tx_minus <= 1'b1;
		@(posedge core_clk);
		#1 chk({4'h0, plus_pin_oe_n, minus_pin_oe_n, plus_pin_out, minus_pin_out}, 8'h01);
		@(posedge core_clk);
		eng_tx_en <= 1'b0;
		host_drive <= 1'b1;
		host_plus <= 1'b1;
		repeat (5) @(posedge core_clk);
		#1 chk({5'h0, eng_rx_plus, eng_rx_minus, eng_rx_diff}, 8'h05);
		wr(UTC_XCVR_CTRL_ADDR, 8'h00);
		chk({4'h0, xcvr_suspend, eng_rx_plus, eng_rx_minus, eng_rx_diff}, 8'h08);
		for (int k = 0; k < 10; k++) begin
			ep = k / 2;
			@(posedge core_clk);
			tok_endpoint <= ep[3:0];
			tok_is_in <= k[0];
			@(posedge core_clk);
			#1;
			ix = (ep > 3) ? 3'h0 : (k[0] ? ((ep == 0) ? 3'h7 : 3'(ep + 3)) : 3'(ep));
			chk({pipe_valid, 4'h0, pipe_index}, {ep <= 3, 4'h0, ix});
			chk(pipe_proto_addr, (ep > 3) ? 8'h00 : {k[0] && ep != 0, 3'h0, 4'(ep)});
		end
		wr(UTC_XCVR_CTRL_ADDR, 8'hE0);
		@(posedge core_clk);
		rst <= 1'b1;
		@(posedge core_clk);
		rst <= 1'b0;
		#1 chk({5'h0, xcvr_suspend, plus_pin_oe_n, minus_pin_oe_n}, 8'h07);
		rd(UTC_XCVR_CTRL_ADDR);
		chk(rv & 8'hF8, 8'h00);
		report_and_stop();
	end
endmodule : tb

// ===== utc_checker.sv
// Port checker for the USB transceiver control front end.
// Assumes it is bound to utc_top and sees only its ports on core_clk.
`timescale 1ns/1ps
module utc_checker
	import utc_pkg::*;
(
	input wire logic       core_clk,
	input wire logic       rst,
	input wire logic [7:0] sfr_addr,
	input wire logic       sfr_wr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire logic       sfr_hit,
	input wire logic       vbus_pin_in,
	input wire logic       plus_pin_oe_n,
	input wire logic       minus_pin_oe_n,
	input wire logic       pullup_plus_on,
	input wire logic       pullup_minus_on,
	input wire logic       xcvr_suspend,
	input wire logic       full_speed,
	input wire logic       eng_rx_plus,
	input wire logic       eng_rx_minus,
	input wire logic       eng_rx_diff,
	input wire logic [3:0] tok_endpoint,
	input wire logic       tok_is_in,
	input wire logic [2:0] pipe_index,
	input wire logic       pipe_valid,
	input wire logic [7:0] pipe_proto_addr
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	a_hit_decode: assert property (
		sfr_hit == ((sfr_wr || sfr_rd) && sfr_addr == UTC_XCVR_CTRL_ADDR))
		else $error("register hit decode wrong");
	a_unmapped_read: assert property (
		sfr_rd && sfr_addr != UTC_XCVR_CTRL_ADDR |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_ctrl_write: assert property (
		sfr_wr && sfr_addr == UTC_XCVR_CTRL_ADDR |=>
			full_speed == $past(sfr_wdata[UTC_SPEED_BIT]) &&
			xcvr_suspend == !$past(sfr_wdata[UTC_XCVR_EN_BIT]))
		else $error("control write not applied");
	a_pullup_plus: assert property (
		pullup_plus_on |-> full_speed)
		else $error("plus pull-up at low speed");
	a_pullup_minus: assert property (
		pullup_minus_on |-> !full_speed)
		else $error("minus pull-up at full speed");
	a_pullup_vbus: assert property (
		!vbus_pin_in [*4] |-> !pullup_plus_on && !pullup_minus_on)
		else $error("pull-up without bus power");
	a_rx_suspend: assert property (
		xcvr_suspend && $past(xcvr_suspend) |->
			{eng_rx_plus, eng_rx_minus, eng_rx_diff} == 3'h0)
		else $error("receiver active in suspend");
	a_oe_suspend: assert property (
		xcvr_suspend [*2] |-> plus_pin_oe_n && minus_pin_oe_n)
		else $error("driver active in suspend");
	a_pipe_refuse: assert property (
		tok_endpoint > 4'h3 |=>
			!pipe_valid && pipe_index == 3'h0 && pipe_proto_addr == 8'h00)
		else $error("bad endpoint decoded");
	a_pipe_addr: assert property (
		tok_endpoint <= 4'h3 |=> pipe_valid && pipe_proto_addr ==
			{$past(tok_is_in) && $past(tok_endpoint) != 4'h0, 3'h0, $past(tok_endpoint)})
		else $error("pipe address wrong");
	a_pipe_index: assert property (
		tok_endpoint <= 4'h3 |=> pipe_index == (($past(tok_endpoint) == 4'h0) ?
			($past(tok_is_in) ? 3'h7 : 3'h0) :
			($past(tok_endpoint[2:0]) + ($past(tok_is_in) ? 3'h3 : 3'h0))))
		else $error("pipe index wrong");
endmodule : utc_checker

bind utc_top utc_checker i_utc_checker (.*);

// ===== utc_host_model.sv
// Host-side line model: D+/D- pull-downs, optional host drive, bus power.
// Assumes the pad outputs and active-low enables of utc_top.
`timescale 1ns/1ps
module utc_host_model (
	input  wire logic host_drive,
	input  wire logic host_plus,
	input  wire logic host_minus,
	input  wire logic vbus_on,
	input  wire logic plus_pin_out,
	input  wire logic plus_pin_oe_n,
	input  wire logic minus_pin_out,
	input  wire logic minus_pin_oe_n,
	input  wire logic pullup_plus_on,
	input  wire logic pullup_minus_on,
	output logic      plus_pin_in,
	output logic      minus_pin_in,
	output logic      diff_rx_pin_in,
	output logic      vbus_pin_in
);
	// Device drive wins, then host drive, then pull-up; host pull-downs hold idle lines low
	assign plus_pin_in    = !plus_pin_oe_n ? plus_pin_out : host_drive ? host_plus : pullup_plus_on;
	assign minus_pin_in   = !minus_pin_oe_n ? minus_pin_out : host_drive ? host_minus : pullup_minus_on;
	assign diff_rx_pin_in = plus_pin_in & ~minus_pin_in;
	// Only the host sources bus power
	assign vbus_pin_in    = vbus_on;
endmodule : utc_host_model

// ===== utc_line_if.sv
// Synchronised line levels passed from the pin synchroniser to the control top.
// Assumes both ends run on core_clk.
`timescale 1ns/1ps
interface utc_line_if;
	logic plus_line_state;
	logic minus_line_state;
	logic diff_receiver_state;
	logic vbus_present;

	modport sync_side (output plus_line_state, output minus_line_state,
		output diff_receiver_state, output vbus_present);
	modport ctrl_side (input plus_line_state, input minus_line_state,
		input diff_receiver_state, input vbus_present);
endinterface : utc_line_if

// ===== utc_line_sync.sv
// Two-flop synchronisers for the asynchronous line and bus-power inputs.
// Assumes raw inputs come straight from pads, unrelated to core_clk.
`timescale 1ns/1ps
module utc_line_sync (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        plus_pin_in,
	input  wire logic        minus_pin_in,
	input  wire logic        diff_rx_pin_in,
	input  wire logic        vbus_pin_in,
	utc_line_if.sync_side    line
);
	import utc_pkg::*;

	logic [3:0] stage1;
	logic [3:0] stage2;

	// Stage1 feeds stage2 only, never any logic
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			stage1 <= 4'h0;
			stage2 <= 4'h0;
		end else begin
			stage1 <= {vbus_pin_in, diff_rx_pin_in, plus_pin_in, minus_pin_in};
			stage2 <= stage1;
		end
	end

	assign line.minus_line_state    = stage2[0];
	assign line.plus_line_state     = stage2[1];
	assign line.diff_receiver_state = stage2[2];
	assign line.vbus_present        = stage2[3];
endmodule : utc_line_sync

// ===== utc_pkg.sv
// Package for the USB transceiver control front end.
// Assumes one core clock domain and an 8-bit special-function register port.
package utc_pkg;
	localparam logic [7:0] UTC_XCVR_CTRL_ADDR  = 8'hD7;
	localparam logic [7:0] UTC_XCVR_CTRL_RESET = 8'h00;
	localparam int         UTC_PULLUP_EN_BIT   = 7;
	localparam int         UTC_XCVR_EN_BIT     = 6;
	localparam int         UTC_SPEED_BIT       = 5;
	localparam int         UTC_TEST_HI_BIT     = 4;
	localparam int         UTC_TEST_LO_BIT     = 3;
	localparam int         UTC_DIFF_RX_BIT     = 2;
	localparam int         UTC_PLUS_BIT        = 1;
	localparam int         UTC_MINUS_BIT       = 0;
	localparam logic [4:0] UTC_RW_RESET        = 5'h00;
	localparam int         UTC_NUM_PIPES       = 8;
	localparam int         UTC_BUF_BYTES       = 1024;
	localparam logic [7:0] UTC_IN_DIR_MASK     = 8'h80;
	localparam logic [7:0] UTC_EP0_ADDR        = 8'h00;
	localparam int         UTC_SYNC_STAGES     = 2;

	typedef enum logic [1:0] {
		UTC_TEST_NORMAL = 2'h0,
		UTC_TEST_DIFF1  = 2'h1,
		UTC_TEST_DIFF0  = 2'h2,
		UTC_TEST_SE0    = 2'h3
	} utc_test_mode_t;
endpackage : utc_pkg

// ===== utc_top.sv
// USB transceiver control: register, pull-up steering, test drive, pipe decode.
// Assumes the serial engine, buffer memory and clock recovery sit outside on core_clk,
// and that D+/D- pads resolve drive from the output enables.
//
// Functional notes
// [RULE_01] The block is a USB peripheral only and has no host-side logic at all.
// [RULE_02] It fronts an engine, a transceiver with pull-ups, a 1k buffer and clock recovery.
// [RULE_03] Exactly eight endpoint pipes are decoded toward the host.
// [RULE_04] Endpoint zero is one bidirectional pipe pair serving both IN and OUT.
// [RULE_05] Endpoints one to three each have a separate IN pipe and OUT pipe.
// [RULE_06] Endpoint zero answers to 0x00 both ways, endpoint n OUT to 0x0n and IN to 0x8n.
// [RULE_07] The control register holds transceiver enable, pull-up enable and speed select.
// [RULE_08] Speed 1 means full speed with the pull-up on D+.
// [RULE_09] Speed 0 means low speed with the pull-up on D-.
// [RULE_10] The pull-up is applied only while bus power is present.
// [RULE_11] Software should start the USB clock before setting transceiver enable.
// [RULE_12] The five low register bits are two test-force bits and three line status bits.
// [RULE_13] The register sits at 0xD7, resets to zero, bits 7-3 read-write and 2-0 read-only.
// [RULE_14] With speed low the function is low speed and an enabled pull-up goes to D-.
// [RULE_15] Transceiver enable low suspends drivers and receivers; pull-up enable low detaches.
// [RULE_16] The status bits show synchronised receiver and single-ended line levels.
`timescale 1ns/1ps
module utc_top #(
	parameter int NUM_PIPES = utc_pkg::UTC_NUM_PIPES,
	parameter int BUF_BYTES = utc_pkg::UTC_BUF_BYTES
) (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic [7:0]  sfr_addr,
	input  wire logic        sfr_wr,
	input  wire logic        sfr_rd,
	input  wire logic [7:0]  sfr_wdata,
	output logic [7:0]       sfr_rdata,
	output logic             sfr_hit,
	input  wire logic        plus_pin_in,
	input  wire logic        minus_pin_in,
	input  wire logic        diff_rx_pin_in,
	input  wire logic        vbus_pin_in,
	output logic             plus_pin_out,
	output logic             plus_pin_oe_n,
	output logic             minus_pin_out,
	output logic             minus_pin_oe_n,
	output logic             pullup_plus_on,
	output logic             pullup_minus_on,
	output logic             xcvr_suspend,
	output logic             full_speed,
	input  wire logic        eng_tx_en,
	input  wire logic        eng_tx_plus,
	input  wire logic        eng_tx_minus,
	output logic             eng_rx_plus,
	output logic             eng_rx_minus,
	output logic             eng_rx_diff,
	input  wire logic [3:0]  tok_endpoint,
	input  wire logic        tok_is_in,
	output logic [2:0]       pipe_index,
	output logic             pipe_valid,
	output logic [7:0]       pipe_proto_addr
);
	import utc_pkg::*;

	utc_line_if line ();

	utc_line_sync u_sync (
		.core_clk       (core_clk),
		.rst            (rst),
		.plus_pin_in    (plus_pin_in),
		.minus_pin_in   (minus_pin_in),
		.diff_rx_pin_in (diff_rx_pin_in),
		.vbus_pin_in    (vbus_pin_in),
		.line           (line.sync_side)
	);

	// Writable part of the control register, bits 7..3
	logic [4:0]     ctrl_rw;
	logic           pullup_enable;
	logic           transceiver_enable;
	logic           speed_sel;
	logic           line_test_sel_hi;
	logic           line_test_sel_lo;
	utc_test_mode_t test_mode;
	logic           reg_sel;
	logic [7:0]     reg_view;
	logic [7:0]     next_rdata;

	assign reg_sel = (sfr_addr == UTC_XCVR_CTRL_ADDR);
	assign sfr_hit = reg_sel & (sfr_wr | sfr_rd);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrl_rw <= UTC_RW_RESET;  // [RULE_13]
		end else if (sfr_wr && reg_sel) begin
			ctrl_rw <= sfr_wdata[UTC_PULLUP_EN_BIT:UTC_TEST_LO_BIT];  // [RULE_13]
		end
	end

	assign pullup_enable      = ctrl_rw[UTC_PULLUP_EN_BIT - UTC_TEST_LO_BIT];  // [RULE_07]
	assign transceiver_enable = ctrl_rw[UTC_XCVR_EN_BIT - UTC_TEST_LO_BIT];    // [RULE_07]
	assign speed_sel          = ctrl_rw[UTC_SPEED_BIT - UTC_TEST_LO_BIT];      // [RULE_07]
	assign line_test_sel_hi   = ctrl_rw[UTC_TEST_HI_BIT - UTC_TEST_LO_BIT];
	assign line_test_sel_lo   = ctrl_rw[0];
	assign test_mode          = utc_test_mode_t'({line_test_sel_hi, line_test_sel_lo});

	// Status bits read the synchronised pads, never the raw pins
	assign reg_view = {ctrl_rw,
		line.diff_receiver_state,
		line.plus_line_state,
		line.minus_line_state};  // [RULE_12] [RULE_16]

	// Unmapped reads return zero; read data lands one cycle after the strobe
	assign next_rdata = (sfr_rd && reg_sel) ? reg_view : 8'h00;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sfr_rdata <= 8'h00;
		end else begin
			sfr_rdata <= next_rdata;  // [RULE_13]
		end
	end

	// Pull-up placement follows speed; bus power gates it regardless of the enable.
	// Speed may be changed live, which moves the pull-up; software should detach first.
	logic pullup_active;
	assign pullup_active   = pullup_enable & line.vbus_present;  // [RULE_10] [RULE_15]
	assign pullup_plus_on  = pullup_active & speed_sel;          // [RULE_08]
	assign pullup_minus_on = pullup_active & ~speed_sel;         // [RULE_09] [RULE_14]
	assign full_speed      = speed_sel;                          // [RULE_08] [RULE_09]

	// Suspend: drivers released and receive path held idle.
	// Nothing here checks that the USB clock runs; that ordering is left to software.
	assign xcvr_suspend = ~transceiver_enable;  // [RULE_15] [RULE_11]

	logic drive_on;
	logic drive_plus;
	logic drive_minus;

	always_comb begin
		unique case (test_mode)  // [RULE_12]
			UTC_TEST_NORMAL: begin
				drive_on    = eng_tx_en;
				drive_plus  = eng_tx_plus;
				drive_minus = eng_tx_minus;
			end
			UTC_TEST_DIFF1: begin
				drive_on    = 1'b1;
				drive_plus  = 1'b1;
				drive_minus = 1'b0;
			end
			UTC_TEST_DIFF0: begin
				drive_on    = 1'b1;
				drive_plus  = 1'b0;
				drive_minus = 1'b1;
			end
			UTC_TEST_SE0: begin
				drive_on    = 1'b1;
				drive_plus  = 1'b0;
				drive_minus = 1'b0;
			end
		endcase
	end

	logic drive_live;
	assign drive_live = drive_on & transceiver_enable;  // [RULE_15]

	// Pad data from flops; the output enable is also registered, through drive_q
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			plus_pin_out  <= 1'b0;
			minus_pin_out <= 1'b0;
		end else begin
			plus_pin_out  <= drive_plus;
			minus_pin_out <= drive_minus;
		end
	end

	logic drive_q;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			drive_q <= 1'b0;
		end else begin
			drive_q <= drive_live;
		end
	end

	assign plus_pin_oe_n  = ~drive_q;
	assign minus_pin_oe_n = ~drive_q;

	// Receive path to the engine is quiet while suspended
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			eng_rx_plus  <= 1'b0;
			eng_rx_minus <= 1'b0;
			eng_rx_diff  <= 1'b0;
		end else begin
			eng_rx_plus  <= line.plus_line_state & transceiver_enable;      // [RULE_15]
			eng_rx_minus <= line.minus_line_state & transceiver_enable;
			eng_rx_diff  <= line.diff_receiver_state & transceiver_enable;
		end
	end

	// Pipe decode: 0 = EP0 OUT, 1..3 OUT, 4..6 IN, 7 = EP0 IN view.
	// Only device-side addressing exists; there is no host token generation.
	logic        ep_known;
	logic [2:0]  next_index;
	logic [7:0]  next_proto;
	localparam int EP_MAX = (NUM_PIPES - 2) / 2;

	assign ep_known = (32'(tok_endpoint) <= EP_MAX);  // [RULE_03] [RULE_01]

	always_comb begin
		next_index = 3'h0;
		next_proto = UTC_EP0_ADDR;
		if (tok_endpoint == 4'h0) begin
			next_index = tok_is_in ? 3'h7 : 3'h0;  // [RULE_04]
			next_proto = UTC_EP0_ADDR;             // [RULE_06]
		end else if (tok_is_in) begin
			next_index = 3'(tok_endpoint) + 3'h3;  // [RULE_05]
			next_proto = UTC_IN_DIR_MASK | {4'h0, tok_endpoint};  // [RULE_06]
		end else begin
			next_index = 3'(tok_endpoint);          // [RULE_05]
			next_proto = {4'h0, tok_endpoint};      // [RULE_06]
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pipe_index      <= 3'h0;
			pipe_valid      <= 1'b0;
			pipe_proto_addr <= 8'h00;
		end else begin
			pipe_index      <= ep_known ? next_index : 3'h0;
			pipe_valid      <= ep_known;
			pipe_proto_addr <= ep_known ? next_proto : 8'h00;
		end
	end

	// Buffer size is carried for the external memory; only a sanity bound here
	localparam int BUF_ADDR_W = $clog2(BUF_BYTES);  // [RULE_02]
	logic [BUF_ADDR_W-1:0] unused_buf_span;
	assign unused_buf_span = '1;
endmodule : utc_top
